// file: hw/incor_defs.vh
// opcode fields and encodings for the increment and or execute unit
// assumes 14-bit instruction words, 8-bit data path
`ifndef INCOR_DEFS_VH
`define INCOR_DEFS_VH

`define INSN_W 14
`define DATA_W 8
`define FADDR_W 7
// top six bits select the instruction
`define OPC_HI 13
`define OPC_LO 8
`define OPC_INC 6'h0A
`define OPC_INCSZ 6'h0F
`define OPC_ORL 6'h1A
`define OPC_ORR 6'h04
// destination select bit
`define DEST_BIT 7
`define NOP_WORD 14'h0000
`define ACC_RESET 8'h00

`endif

// file: hw/incor_exec.v
// execute unit for increment, increment-skip-zero, or-literal, or-register
// assumes data memory is read combinationally by address and written
// on the clock edge when the write strobe is high; one instruction a clock
`timescale 1ns/1ps
`include "incor_defs.vh"

// Function
// - increment_op adds one, writes destination, updates zero flag.
// - increment_skip_zero_op skips next word on zero, flags untouched.
// - destination bit zero selects accumulator, one selects the register.
// - register operand is seven bits, 00h to 7Fh, plus destination bit.
// - or_literal_op ors literal into accumulator, updates zero flag.
// - or_register_op ors register with accumulator into destination.
module incor_exec #(
    parameter DATA_W = `DATA_W,
    parameter FADDR_W = `FADDR_W
) (
    input wire clk,
    input wire rstn,
    input wire insn_valid,
    input wire [`INSN_W-1:0] insn,
    input wire [DATA_W-1:0] file_rdata,
    output wire [FADDR_W-1:0] file_addr,
    output reg file_we,
    output reg [DATA_W-1:0] file_wdata,
    output reg [DATA_W-1:0] acc,
    output reg result_null_flag,
    output reg skip_slot,
    output reg insn_done
);

    // one instruction word is presented per clock with insn_valid; the
    // result of the word is visible at the ports one clock later
    // the data memory answers combinationally, so file_rdata must belong
    // to file_addr of the same word; the write lands one clock later and
    // the memory must latch the address of the word that produced it
    // a skip arms the squash slot, which drops the next valid word and
    // not simply the next clock, so gaps in insn_valid are harmless

    // controller states: normal execute or squash of the next word
    localparam ST_RUN = 1'b0;
    localparam ST_SQUASH = 1'b1;

    // opcode codes, six bits above the destination bit
    localparam [5:0] OP_INC = `OPC_INC;
    localparam [5:0] OP_INCSZ = `OPC_INCSZ;
    localparam [5:0] OP_ORL = `OPC_ORL;
    localparam [5:0] OP_ORR = `OPC_ORR;

    // constants at data width
    localparam [DATA_W-1:0] ONE = {{(DATA_W-1){1'b0}}, 1'b1};
    localparam [DATA_W-1:0] ZERO = {DATA_W{1'b0}};

    // decoded instruction fields
    wire [5:0] opc;
    wire dest;
    wire [DATA_W-1:0] lit;

    assign opc = insn[`OPC_HI:`OPC_LO];
    assign dest = insn[`DEST_BIT];
    assign lit = insn[DATA_W-1:0];
    assign file_addr = insn[FADDR_W-1:0];

    // decode of the four supported opcodes
    wire is_inc;
    wire is_incsz;
    wire is_orl;
    wire is_orr;

    assign is_inc = (opc == OP_INC);
    assign is_incsz = (opc == OP_INCSZ);
    assign is_orl = (opc == OP_ORL);
    assign is_orr = (opc == OP_ORR);

    // architectural state and next values
    reg [DATA_W-1:0] acc_q;
    reg [DATA_W-1:0] acc_d;
    reg flag_q;
    reg flag_d;
    reg state_q;
    reg state_d;
    reg we_d;
    reg [DATA_W-1:0] wdata_d;

    // a word is executed only outside the squash slot
    wire take;
    wire squash;

    assign take = insn_valid && (state_q == ST_RUN);
    assign squash = insn_valid && (state_q == ST_SQUASH);

    // per-bit or of accumulator with register and with literal
    wire [DATA_W-1:0] or_reg;
    wire [DATA_W-1:0] or_lit;
    wire [DATA_W-1:0] inc_sum;
    // zero chain: bit i+1 is high when any result bit below it is set
    wire [DATA_W:0] res_any;
    reg [DATA_W-1:0] res;
    wire res_zero;

    assign inc_sum = file_rdata + ONE;
    assign res_any[0] = 1'b0;

    // the carry out of the incrementer is dropped on purpose, so all
    // ones wraps to zero and the zero detect sees it
    genvar i;
    generate
        for (i = 0; i < DATA_W; i = i + 1) begin : g_bit
            assign or_reg[i] = acc_q[i] | file_rdata[i];
            assign or_lit[i] = acc_q[i] | lit[i];
            assign res_any[i+1] = res_any[i] | res[i];
        end
    endgenerate

    // wraparound from all ones gives zero here as well
    assign res_zero = ~res_any[DATA_W];

    // result select for the decoded opcode
    always @* begin
        res = ZERO;
        case (opc)
            OP_INC: begin
                res = inc_sum;
            end
            OP_INCSZ: begin
                res = inc_sum;
            end
            OP_ORL: begin
                res = or_lit;
            end
            OP_ORR: begin
                res = or_reg;
            end
            default: begin
                res = ZERO;
            end
        endcase
    end

    // next state of accumulator, flag, squash slot and write strobe
    // unknown opcodes fall through with nothing changed; a squashed
    // word changes nothing but the slot itself
    always @* begin
        acc_d = acc_q;
        flag_d = flag_q;
        state_d = state_q;
        we_d = 1'b0;
        wdata_d = res;
        case (state_q)
            ST_RUN: begin
                if (take) begin
                    if (is_orl) begin
                        // literal form always lands in the accumulator
                        acc_d = res;
                        flag_d = res_zero;
                    end else if (is_inc || is_orr) begin
                        flag_d = res_zero;
                        if (dest)
                            we_d = 1'b1;
                        else
                            acc_d = res;
                    end else if (is_incsz) begin
                        // flags untouched, destination written, slot armed on a zero result
                        if (dest)
                            we_d = 1'b1;
                        else
                            acc_d = res;
                        if (res_zero)
                            state_d = ST_SQUASH;
                    end
                end
            end
            ST_SQUASH: begin
                // the next valid word is dropped, acting as a no-op
                if (squash)
                    state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // state registers, synchronous active-low reset
    // reset leaves the slot disarmed so the first word always runs
    always @(posedge clk) begin
        if (!rstn) begin
            acc_q <= `ACC_RESET;
            flag_q <= 1'b0;
            state_q <= ST_RUN;
        end else begin
            acc_q <= acc_d;
            flag_q <= flag_d;
            state_q <= state_d;
        end
    end

    // registered memory write port and completion pulse
    // insn_done lasts one clock per valid word, file_we one clock per word that writes the register
    always @(posedge clk) begin
        if (!rstn) begin
            file_we <= 1'b0;
            file_wdata <= ZERO;
            insn_done <= 1'b0;
        end else begin
            file_we <= we_d;
            file_wdata <= wdata_d;
            insn_done <= insn_valid;
        end
    end

    // architectural state seen at the ports
    // all three come straight from flip-flops
    always @* begin
        acc = acc_q;
        result_null_flag = flag_q;
        skip_slot = (state_q == ST_SQUASH);
    end

endmodule // incor_exec

// file: tb/incor_exec_sva.sv
// incor_exec checker
// assumes it is bound into incor_exec and sees only its ports
`timescale 1ns/1ps
module incor_exec_sva(input wire clk,rstn,insn_valid,file_we,
result_null_flag,skip_slot,insn_done,input wire [13:0] insn,
input wire [7:0] file_rdata,file_wdata,acc,input wire [6:0] file_addr);
default clocking @(posedge clk);endclocking
default disable iff(!rstn);
wire v=insn_valid&&!skip_slot;
wire [5:0] o=insn[13:8];
wire [7:0] s=file_rdata+8'h01,m=acc|file_rdata,n=acc|insn[7:0];
a_inc:assert property(v&&o==6'h0A&&insn[7]|=>
file_we&&file_wdata==$past(s))else $error("inc");
a_skz:assert property(v&&o==6'h0F&&!s|=>
skip_slot&&$stable(result_null_flag))else $error("skz");
a_dst:assert property(v&&o==6'h0A&&!insn[7]|=>
!file_we&&acc==$past(s))else $error("dst");
a_adr:assert property(file_addr==insn[6:0])else $error("adr");
a_orl:assert property(v&&o==6'h1A|=>acc==$past(n))else $error("orl");
a_orr:assert property(v&&o==6'h04&&insn[7]|=>
file_wdata==$past(m))else $error("orr");
a_z:assert property(v&&o==6'h1A|=>result_null_flag==!acc)
else $error("z");
a_sq:assert property(insn_valid&&skip_slot|=>
!skip_slot&&!file_we&&$stable(acc))else $error("sq");
a_zi:assert property(v&&o==6'h0A|=>result_null_flag==!$past(s))
else $error("zi");
a_dn:assert property(insn_valid|=>insn_done)else $error("dn");
endmodule // incor_exec_sva
bind incor_exec incor_exec_sva chk_u(.*);

// file: tb/increment_and_or_instruction_exec_tb_top.sv
// scenario bench for the increment and or execute unit
// assumes the unit answers one clock after each valid word
`timescale 1ns/1ps
module increment_and_or_instruction_exec_tb_top;
reg clk=0,rstn=0,insn_valid=0;
reg [13:0] insn=0;
reg [7:0] file_rdata=0;
wire [6:0] file_addr;
wire [7:0] file_wdata,acc;
wire file_we,result_null_flag,skip_slot,insn_done;
integer n_fail=0,cmp_count=0;
incor_exec dut_u(.clk(clk),.rstn(rstn),.insn_valid(insn_valid),.insn(insn),
.file_rdata(file_rdata),.file_addr(file_addr),.file_we(file_we),
.file_wdata(file_wdata),.acc(acc),.result_null_flag(result_null_flag),
.skip_slot(skip_slot),.insn_done(insn_done));
initial forever #4 clk=!clk;
task chk(input [63:0] nm,input [7:0] e,s);
begin cmp_count=cmp_count+1;
if(e!==s)begin n_fail=n_fail+1;$display("mismatch %0s %h %h",nm,e,s);end
end
endtask
task run(input [13:0] w,input [7:0] r,e,wd,input f,we,sk);
begin
@(posedge clk);insn_valid<=1;insn<=w;file_rdata<=r;
@(posedge clk);insn_valid<=0;#1;
chk("acc",e,acc);
chk("flag",{7'h00,f},{7'h00,result_null_flag});
chk("skip",{7'h00,sk},{7'h00,skip_slot});
chk("we",{7'h00,we},{7'h00,file_we});
if(we)chk("wdata",wd,file_wdata);
chk("done",8'h01,{7'h00,insn_done});
end
endtask
task t_a;
run(14'h0A85,8'hFF,8'h00,8'h00,1,1,0);
run(14'h0A7F,8'h41,8'h42,8'h00,0,0,0);
run(14'h1A35,8'h00,8'h77,8'h00,0,0,0);
run(14'h0490,8'h80,8'h77,8'hF7,0,1,0);
$display("t_a");
endtask
task t_b;
run(14'h0F01,8'hFF,8'h00,8'h00,0,0,1);
run(14'h1A01,8'h00,8'h00,8'h00,0,0,0);
run(14'h0F81,8'h05,8'h00,8'h06,0,1,0);
run(14'h1A00,8'h00,8'h00,8'h00,1,0,0);
run(14'h0F02,8'hFF,8'h00,8'h00,1,0,1);
run(14'h0A00,8'h00,8'h00,8'h00,1,0,0);
$display("t_b");
endtask
task results;
$display("n %0d f %0d",cmp_count,n_fail);
if(n_fail==0&&cmp_count>0)$display("[ PASS ]");
else $display("[ FAIL ]");
$finish;
endtask
initial begin #9000;n_fail++;results;end
initial begin repeat(8)@(posedge clk);rstn<=1;t_a;t_b;results;end
endmodule // increment_and_or_instruction_exec_tb_top
